// ==== olair_pkg.sv ====
// Package with register offsets, reset values and timing for the alarm register slice
package olair_pkg;
  localparam logic [7:0] ADDR_FAULT_IRQ_EN  = 8'h07;
  localparam logic [7:0] ADDR_LOS_IRQ_EN    = 8'h06;
  localparam logic [7:0] ADDR_LOS_CHANGE    = 8'h08;
  localparam logic [7:0] ADDR_FAULT_CHANGE  = 8'h09;
  localparam logic [7:0] ADDR_SOFT_RESET    = 8'h0A;
  localparam logic [7:0] ADDR_MONITOR_SEL   = 8'h0B;
  localparam logic [7:0] RST_REG            = 8'h00;
  localparam logic [3:0] RST_SEL            = 4'h0;
  localparam int         CLK_PERIOD_PS      = 25000;
  localparam int         SOFT_RESET_TIME_NS = 1000;
  localparam int         SOFT_RESET_CYCLES  = (SOFT_RESET_TIME_NS * 1000 + CLK_PERIOD_PS - 1)
                                              / CLK_PERIOD_PS;
  localparam logic [5:0] SOFT_RESET_LAST    = 6'(SOFT_RESET_CYCLES - 1);
endpackage : olair_pkg

// ==== olair_regs.sv ====
// Alarm interrupt enable, change status, soft reset and monitor select registers
`timescale 1ns/1ps

module olair_regs (
  input  wire logic       clk_sys,
  input  wire logic       rst_n,
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  input  wire logic [7:0] los_status,
  input  wire logic [7:0] fault_status,
  output logic            irq,
  output logic            soft_reset_busy,
  output logic            monitor_enable,
  output logic            monitor_is_transmitter,
  output logic      [2:0] monitor_channel
);

  logic [7:0] fault_irq_en_ff;
  logic [7:0] los_irq_en_ff;
  logic [7:0] los_change_ff;
  logic [7:0] fault_change_ff;
  logic [7:0] los_prev_ff;
  logic [7:0] fault_prev_ff;
  logic [3:0] monitor_sel_ff;
  logic [5:0] srst_cnt_ff;
  logic       srst_busy_ff;
  logic [7:0] rdata_ff;
  logic       irq_ff;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
    hit = (a == o);
  endfunction : hit

  wire        wr_fault_en = reg_wr && hit(reg_addr, olair_pkg::ADDR_FAULT_IRQ_EN);
  wire        wr_los_en   = reg_wr && hit(reg_addr, olair_pkg::ADDR_LOS_IRQ_EN);
  wire        wr_srst     = reg_wr && hit(reg_addr, olair_pkg::ADDR_SOFT_RESET);
  wire        wr_monitor  = reg_wr && hit(reg_addr, olair_pkg::ADDR_MONITOR_SEL);
  wire        rd_los      = reg_rd && hit(reg_addr, olair_pkg::ADDR_LOS_CHANGE);
  wire        rd_fault    = reg_rd && hit(reg_addr, olair_pkg::ADDR_FAULT_CHANGE);
  // Soft reset acts like rst_n on every register except rdata_ff and the soft reset counter, and the edge history is refreshed
  wire        clr_all     = !rst_n || srst_busy_ff;
  wire [7:0]  los_edge    = los_status ^ los_prev_ff;
  wire [7:0]  fault_edge  = fault_status ^ fault_prev_ff;
  // Set wins over the read clear so an edge in the read cycle is not lost
  wire [7:0]  nxt_los_change   = (rd_los ? 8'h00 : los_change_ff) | los_edge;
  wire [7:0]  nxt_fault_change = (rd_fault ? 8'h00 : fault_change_ff) | fault_edge;
  wire        nxt_irq = |((los_change_ff & los_irq_en_ff) |
                          (fault_change_ff & fault_irq_en_ff));
  logic [7:0] nxt_rdata;

  always_comb begin
    nxt_rdata = 8'h00;
    case (reg_addr)
      olair_pkg::ADDR_FAULT_IRQ_EN: nxt_rdata = fault_irq_en_ff;
      olair_pkg::ADDR_LOS_IRQ_EN:   nxt_rdata = los_irq_en_ff;
      olair_pkg::ADDR_LOS_CHANGE:   nxt_rdata = los_change_ff;
      olair_pkg::ADDR_FAULT_CHANGE: nxt_rdata = fault_change_ff;
      olair_pkg::ADDR_SOFT_RESET:   nxt_rdata = 8'h00;
      // Spare bits read as zero
      olair_pkg::ADDR_MONITOR_SEL:  nxt_rdata = {4'h0, monitor_sel_ff};
      default:                      nxt_rdata = 8'h00;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      srst_busy_ff <= 1'b0;
      srst_cnt_ff  <= 6'h00;
    end else if (srst_busy_ff) begin
      srst_cnt_ff  <= srst_cnt_ff + 6'h01;
      srst_busy_ff <= (srst_cnt_ff != olair_pkg::SOFT_RESET_LAST);
    end else if (wr_srst) begin
      srst_busy_ff <= 1'b1;
      srst_cnt_ff  <= 6'h00;
    end
  end

  // Enables: host writes are dropped while a soft reset cycle runs
  always_ff @(posedge clk_sys) begin
    if (clr_all) begin
      fault_irq_en_ff <= olair_pkg::RST_REG;
      los_irq_en_ff   <= olair_pkg::RST_REG;
    end else begin
      if (wr_fault_en) fault_irq_en_ff <= reg_wdata;
      if (wr_los_en) los_irq_en_ff <= reg_wdata;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (clr_all) begin
      monitor_sel_ff <= olair_pkg::RST_SEL;
    end else if (wr_monitor) begin
      monitor_sel_ff <= reg_wdata[3:0];
    end
  end

  // Change bits: set wins over the read clear
  always_ff @(posedge clk_sys) begin
    if (clr_all) begin
      los_change_ff   <= olair_pkg::RST_REG;
      fault_change_ff <= olair_pkg::RST_REG;
    end else begin
      los_change_ff   <= nxt_los_change;
      fault_change_ff <= nxt_fault_change;
    end
  end

  // History always tracks the inputs, so no false edge follows any reset
  always_ff @(posedge clk_sys) begin
    los_prev_ff   <= los_status;
    fault_prev_ff <= fault_status;
  end

  always_ff @(posedge clk_sys) begin
    if (clr_all) begin
      irq_ff <= 1'b0;
    end else begin
      irq_ff <= nxt_irq;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) rdata_ff <= 8'h00;
    else rdata_ff <= nxt_rdata;
  end

  assign reg_rdata          = rdata_ff;
  assign irq                = irq_ff;
  assign soft_reset_busy    = srst_busy_ff;
  assign monitor_enable         = (monitor_sel_ff[2:0] != 3'h0);
  assign monitor_is_transmitter = monitor_sel_ff[3];
  // Channel code 1..7 maps straight to channel number; 1..7 receivers when group clear
  assign monitor_channel        = monitor_sel_ff[2:0];

  a_srst_length: assert property (@(posedge clk_sys) disable iff (!rst_n)
    $rose(srst_busy_ff) |-> srst_busy_ff [*8] ##32 srst_busy_ff ##1 !srst_busy_ff)
    else $error("soft reset cycle length wrong");
  a_srst_clears: assert property (@(posedge clk_sys) disable iff (!rst_n)
    $fell(srst_busy_ff) |-> fault_irq_en_ff == 8'h00 && monitor_sel_ff == 4'h0)
    else $error("soft reset did not restore defaults");
  a_srst_start: assert property (@(posedge clk_sys) disable iff (!rst_n)
    wr_srst && !srst_busy_ff |=> srst_busy_ff)
    else $error("soft reset write did not start a cycle");
  a_srst_refuse: assert property (@(posedge clk_sys) disable iff (!rst_n)
    srst_busy_ff |=> fault_irq_en_ff == 8'h00 && los_irq_en_ff == 8'h00 &&
      monitor_sel_ff == 4'h0)
    else $error("register changed during soft reset");
  a_fault_en_wr: assert property (@(posedge clk_sys) disable iff (!rst_n)
    wr_fault_en && !srst_busy_ff |=> fault_irq_en_ff == $past(reg_wdata))
    else $error("fault enable write lost");
  a_los_en_wr: assert property (@(posedge clk_sys) disable iff (!rst_n)
    wr_los_en && !srst_busy_ff |=> los_irq_en_ff == $past(reg_wdata))
    else $error("los enable write lost");
  a_reset_zero: assert property (@(posedge clk_sys)
    !rst_n |=> fault_irq_en_ff == 8'h00 && los_change_ff == 8'h00)
    else $error("reset values wrong");
  a_los_set: assert property (@(posedge clk_sys) disable iff (!rst_n || srst_busy_ff)
    |los_edge |=> (los_change_ff & $past(los_edge)) == $past(los_edge))
    else $error("los change not latched");
  a_los_hold: assert property (@(posedge clk_sys) disable iff (!rst_n || srst_busy_ff)
    !rd_los && los_edge == 8'h00 |=> $stable(los_change_ff))
    else $error("los change moved without cause");
  a_fault_set: assert property (@(posedge clk_sys) disable iff (!rst_n || srst_busy_ff)
    |fault_edge |=> (fault_change_ff & $past(fault_edge)) == $past(fault_edge))
    else $error("fault change not latched");
  a_fault_hold: assert property (@(posedge clk_sys) disable iff (!rst_n || srst_busy_ff)
    !rd_fault && fault_edge == 8'h00 |=> $stable(fault_change_ff))
    else $error("fault change moved without cause");
  a_los_rdclr: assert property (@(posedge clk_sys) disable iff (!rst_n || srst_busy_ff)
    rd_los && los_edge == 8'h00 |=> los_change_ff == 8'h00)
    else $error("los read did not clear");
  a_los_rd_data: assert property (@(posedge clk_sys) disable iff (!rst_n)
    rd_los |=> reg_rdata == $past(los_change_ff))
    else $error("los read returned wrong data");
  a_fault_rdclr: assert property (@(posedge clk_sys) disable iff (!rst_n || srst_busy_ff)
    rd_fault && fault_edge == 8'h00 |=> fault_change_ff == 8'h00)
    else $error("fault read did not clear");
  a_fault_rd_data: assert property (@(posedge clk_sys) disable iff (!rst_n)
    rd_fault |=> reg_rdata == $past(fault_change_ff))
    else $error("fault read returned wrong data");
  a_monitor_off: assert property (@(posedge clk_sys) disable iff (!rst_n || srst_busy_ff)
    wr_monitor && reg_wdata[2:0] == 3'h0 |=> !monitor_enable)
    else $error("monitor routed with zero select");
  a_monitor_write: assert property (@(posedge clk_sys) disable iff (!rst_n || srst_busy_ff)
    wr_monitor |=> {4'h0, monitor_is_transmitter, monitor_channel} ==
      ($past(reg_wdata) & 8'h0F))
    else $error("monitor group or channel wrong");
  a_rx_map: assert property (@(posedge clk_sys) disable iff (!rst_n || srst_busy_ff)
    wr_monitor && !reg_wdata[3] |=> !monitor_is_transmitter &&
      {5'h00, monitor_channel} == ($past(reg_wdata) & 8'h07))
    else $error("receiver monitor mapping wrong");
  a_irq_cause: assert property (@(posedge clk_sys) disable iff (!rst_n || srst_busy_ff)
    nxt_irq |=> irq)
    else $error("interrupt not raised");
  a_irq_quiet: assert property (@(posedge clk_sys) disable iff (!rst_n || srst_busy_ff)
    !nxt_irq |=> !irq)
    else $error("interrupt raised without cause");

  c_srst: cover property (@(posedge clk_sys) disable iff (!rst_n) $fell(srst_busy_ff));
  c_irq:  cover property (@(posedge clk_sys) disable iff (!rst_n) $rose(irq));
  c_rdclr: cover property (@(posedge clk_sys) disable iff (!rst_n)
    rd_los && los_change_ff != 8'h00);
  c_monitor_tx: cover property (@(posedge clk_sys) disable iff (!rst_n)
    monitor_enable && monitor_is_transmitter);
  c_rx5: cover property (@(posedge clk_sys) disable iff (!rst_n)
    monitor_enable && !monitor_is_transmitter && monitor_channel == 3'h5);

endmodule : olair_regs

// ==== olair_line_model.sv ====
// Line-side model driving loss-of-signal and driver-fault levels
`timescale 1ns/1ps
module olair_line_model (
  input  wire logic       clk_sys,
  input  wire logic [7:0] los_req,
  input  wire logic [7:0] fault_req,
  output logic      [7:0] los_status,
  output logic      [7:0] fault_status
);
  initial begin
    los_status   = 8'h00;
    fault_status = 8'h00;
  end
  // Levels move just after the edge, like a synchronous detector output
  always @(posedge clk_sys) begin
    los_status   <= #1 los_req;
    fault_status <= #1 fault_req;
  end
endmodule : olair_line_model

// ==== tb_olair_regs.sv ====
// Self-checking testbench for the alarm register slice
`timescale 1ns/1ps
module tb_olair_regs;
  logic       clk_sys = 1'b0;
  logic       rst_n = 1'b0;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
  logic       reg_wr = 1'b0, reg_rd = 1'b0, irq, soft_reset_busy;
  logic       monitor_enable, monitor_is_transmitter;
  logic [2:0] monitor_channel;
  logic [7:0] los_req = 8'h00, fault_req = 8'h00, los_status, fault_status;
  int         err_total = 0, tests_run = 0, n;
  always #12.5 clk_sys = ~clk_sys;
  olair_regs i_olair_regs (.clk_sys(clk_sys), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .los_status(los_status), .fault_status(fault_status), .irq(irq),
    .soft_reset_busy(soft_reset_busy), .monitor_enable(monitor_enable),
    .monitor_is_transmitter(monitor_is_transmitter), .monitor_channel(monitor_channel));
  olair_line_model i_olair_line_model (.clk_sys(clk_sys), .los_req(los_req),
    .fault_req(fault_req), .los_status(los_status), .fault_status(fault_status));
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk
  // An idle edge before each access keeps strobes from being driven twice in one step
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    #1 reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(posedge clk_sys);
    #1 reg_wr = 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk_sys);
    #1 reg_addr = a;
    reg_rd = 1'b1;
    @(posedge clk_sys);
    #1 reg_rd = 1'b0;
    chk(reg_rdata, exp);
  endtask : rd
  task automatic stop_test();
    if (err_total == 0 && tests_run > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : stop_test
  initial begin
    repeat (2) @(posedge clk_sys);
    #1 rst_n = 1'b1;
    rd(8'h07, 8'h00);
    rd(8'h06, 8'h00);
    rd(8'h08, 8'h00);
    wr(8'h07, 8'hA5);
    rd(8'h07, 8'hA5);
    wr(8'h06, 8'h3C);
    rd(8'h06, 8'h3C);
    los_req = 8'h04;
    repeat (3) @(posedge clk_sys);
    #1 chk({7'h00, irq}, 8'h01);
    rd(8'h08, 8'h04);
    rd(8'h08, 8'h00);
    chk({7'h00, irq}, 8'h00);
    los_req = 8'h00;
    repeat (3) @(posedge clk_sys);
    rd(8'h08, 8'h04);
    fault_req = 8'h81;
    repeat (3) @(posedge clk_sys);
    #1 chk({7'h00, irq}, 8'h01);
    rd(8'h09, 8'h81);
    rd(8'h09, 8'h00);
    // Receiver 0 is not enabled, so its change bit must not interrupt
    los_req = 8'h01;
    repeat (3) @(posedge clk_sys);
    #1 chk({7'h00, irq}, 8'h00);
    rd(8'h08, 8'h01);
    for (int v = 0; v < 16; v++) begin
      wr(8'h0B, 8'hF0 | 8'(v));
      chk({4'h0, monitor_is_transmitter, monitor_channel}, 8'(v));
      chk({7'h00, monitor_enable}, {7'h00, v[2:0] != 3'h0});
      rd(8'h0B, 8'(v));
    end
    // Leave a change bit pending so the soft reset has something to clear
    los_req = 8'h00;
    wr(8'h0A, 8'hFF);
    n = 0;
    while (soft_reset_busy === 1'b1 && n < 100) begin
      n++;
      @(posedge clk_sys);
      #1;
    end
    chk(8'(n), 8'(1000 / 25));
    if (n < 100) begin
      // Host holds off until 2 us after the reset write
      repeat (40) @(posedge clk_sys);
      rd(8'h07, 8'h00);
      rd(8'h06, 8'h00);
      rd(8'h0B, 8'h00);
      rd(8'h08, 8'h00);
      wr(8'h07, 8'h5A);
      rst_n = 1'b0;
      repeat (2) @(posedge clk_sys);
      #1 rst_n = 1'b1;
      rd(8'h07, 8'h00);
    end
    stop_test();
  end
endmodule : tb_olair_regs
